// *** logic/dhrs_consts.svh ***
/*
 * Timing figures and layout constants for the display hardware reset sequencer.
 * Assumes a 100 MHz system clock; counts are derived where they are used.
 */
`ifndef DHRS_CONSTS_SVH
`define DHRS_CONSTS_SVH

`define DHRS_CLK_MHZ 100
`define DHRS_CYC_PER_MS 100000
// Pin pulses below this are always rejected
`define DHRS_GLITCH_REJECT_US 5
// Pin pulses above this are always accepted
`define DHRS_GLITCH_ACCEPT_US 9
// Filter decision point, inside the undefined band
`define DHRS_FILTER_US 7
`define DHRS_REL_SLEEP_MS 5
`define DHRS_REL_AWAKE_MS 120
`define DHRS_BLANK_SEQ_MS 120
`define DHRS_NVM_WORDS 4
`define DHRS_ID_BYTES 3
`define DHRS_COMMON_ELECTRODE_LEVEL_IDX 3
`define DHRS_RST_SETTING 8'h00

`endif

// *** logic/dhrs_pkg.sv ***
/*
 * Types shared by the reset sequencer and its settings loader.
 * Assumes dhrs_consts.svh sits on the include path.
 */
package dhrs_pkg;

    typedef enum logic [1:0] {
        DHRS_RUN,
        DHRS_HOLD,
        DHRS_RELEASE
    } dhrs_state_t;

    typedef struct packed {
        dhrs_state_t state;
        logic pin_s1;
        logic pin_s2;
        logic pin_f;
        logic [15:0] filt_cnt;
        logic sleep_out;
        logic awake_at_rst;
        logic blank_seq;
        logic [24:0] tmr;
        logic load_start;
        logic panel_blank;
        logic core_rst;
        logic cmd_ok;
    } dhrs_top_st_t;

endpackage

// *** logic/dhrs_nvm_if.sv ***
/*
 * Start and done handshake between the sequencer and the settings loader.
 * Assumes both ends share the system clock.
 */
`timescale 1ns/100ps

interface dhrs_nvm_if;
    logic start;
    logic done;

    modport seq (output start, input done);
    modport ld (input start, output done);
endinterface

// *** logic/dhrs_nvm_loader.sv ***
/*
 * Copies stored identification and panel settings from nonvolatile memory
 * into registers. Assumes a memory with one cycle of read latency.
 */
`timescale 1ns/100ps
`include "dhrs_consts.svh"

module dhrs_nvm_loader import dhrs_pkg::*; #(
    parameter int NVM_WORDS = `DHRS_NVM_WORDS
) (
    input wire logic clock,
    input wire logic sys_rst,
    dhrs_nvm_if.ld ctl,
    output logic [7:0] nvm_addr,
    input wire logic [7:0] nvm_rdata,
    output logic [NVM_WORDS*8-1:0] settings
);

    typedef struct packed {
        logic busy;
        logic phase;
        logic [7:0] idx;
        logic done;
        logic [NVM_WORDS-1:0][7:0] words;
    } dhrs_ld_st_t;

    dhrs_ld_st_t q, d;

    always_comb begin
        d = q;
        d.done = 1'b0;
        if (ctl.start) begin
            d.busy = 1'b1;
            d.phase = 1'b0;
            d.idx = 8'h00;
        end else if (q.busy) begin
            d.phase = ~q.phase;
            if (q.phase) begin
                d.words[q.idx] = nvm_rdata;
                d.idx = q.idx + 8'h01;
                if (q.idx == 8'(NVM_WORDS - 1)) begin
                    d.busy = 1'b0;
                    d.done = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign nvm_addr = q.idx;
    assign ctl.done = q.done;
    assign settings = q.words;

endmodule

// *** logic/dhrs_top.sv ***
/*
 * Hardware reset sequencer of a display driver: filters the reset pin,
 * blanks the panel, reloads stored settings and restores defaults.
 * Assumes an asynchronous active-low reset pin and a 100 MHz clock.
 */
`timescale 1ns/100ps
`include "dhrs_consts.svh"

module dhrs_top import dhrs_pkg::*; #(
    parameter int NVM_WORDS = `DHRS_NVM_WORDS,
    parameter int REL_SLEEP_CYC = `DHRS_REL_SLEEP_MS * `DHRS_CYC_PER_MS,
    parameter int REL_AWAKE_CYC = `DHRS_REL_AWAKE_MS * `DHRS_CYC_PER_MS,
    parameter int BLANK_SEQ_CYC = `DHRS_BLANK_SEQ_MS * `DHRS_CYC_PER_MS
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic hw_reset_pin_n,
    input wire logic wake_cmd,
    input wire logic sleep_cmd,
    output logic panel_blank,
    output logic blank_seq_active,
    output logic core_rst,
    output logic sleep_out,
    output logic cmd_ready,
    output logic [7:0] nvm_addr,
    input wire logic [7:0] nvm_rdata,
    output logic [`DHRS_ID_BYTES*8-1:0] id_bytes,
    output logic [7:0] common_electrode_level,
    output logic [NVM_WORDS*8-1:0] settings
);

    localparam int FILT_CYC = `DHRS_FILTER_US * `DHRS_CLK_MHZ;
    localparam logic [15:0] FILT_CNT = 16'(FILT_CYC - 1);

    dhrs_top_st_t q, d;
    dhrs_nvm_if nvm_ctl ();
    logic [NVM_WORDS*8-1:0] ld_words;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_comb begin
        d = q;
        d.pin_s1 = hw_reset_pin_n;
        d.pin_s2 = q.pin_s1;
        d.load_start = 1'b0;
        // Level must differ from the filtered one for the whole window
        if (q.pin_s2 == q.pin_f) begin
            d.filt_cnt = 16'h0000;
        end else if (q.filt_cnt == FILT_CNT) begin
            d.pin_f = q.pin_s2;
            d.filt_cnt = 16'h0000;
        end else begin
            d.filt_cnt = q.filt_cnt + 16'h0001;
        end
        if (q.tmr != 25'h0) begin
            d.tmr = q.tmr - 25'h1;
        end
        unique case (q.state)
            DHRS_RUN: begin
                if (wake_cmd) begin
                    d.sleep_out = 1'b1;
                end else if (sleep_cmd) begin
                    d.sleep_out = 1'b0;
                end
                if (!q.pin_f) begin
                    d.state = DHRS_HOLD;
                    d.awake_at_rst = q.sleep_out;
                    d.blank_seq = q.sleep_out;
                    d.tmr = 25'(BLANK_SEQ_CYC - 1);
                    d.core_rst = 1'b1;
                    d.cmd_ok = 1'b0;
                end
            end
            DHRS_HOLD: begin
                if (q.blank_seq && q.tmr == 25'h0) begin
                    d.blank_seq = 1'b0;
                end
                if (q.pin_f) begin
                    d.state = DHRS_RELEASE;
                    d.blank_seq = 1'b0;
                    d.load_start = 1'b1;
                    d.tmr = q.awake_at_rst ? 25'(REL_AWAKE_CYC - 1)
                                           : 25'(REL_SLEEP_CYC - 1);
                end
            end
            DHRS_RELEASE: begin
                if (!q.pin_f) begin
                    d.state = DHRS_HOLD;
                    d.blank_seq = 1'b0;
                end else if (q.tmr == 25'h0) begin
                    d.state = DHRS_RUN;
                    d.sleep_out = 1'b0;
                    d.core_rst = 1'b0;
                    d.cmd_ok = 1'b1;
                end
            end
        endcase
        d.panel_blank = (d.state != DHRS_RUN) || !d.sleep_out;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            q <= '0;
            q.pin_s1 <= 1'b1;
            q.pin_s2 <= 1'b1;
            q.pin_f <= 1'b1;
            q.panel_blank <= 1'b1;
            q.cmd_ok <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign nvm_ctl.start = q.load_start;

    ////////////////////////////////////////////////////////////////////////
    // Stored settings

    dhrs_nvm_loader #(
        .NVM_WORDS(NVM_WORDS)
    ) u_loader (
        .clock(clock),
        .sys_rst(sys_rst),
        .ctl(nvm_ctl),
        .nvm_addr(nvm_addr),
        .nvm_rdata(nvm_rdata),
        .settings(ld_words)
    );

    assign settings = ld_words;
    assign id_bytes = ld_words[`DHRS_ID_BYTES*8-1:0];
    assign common_electrode_level = ld_words[`DHRS_COMMON_ELECTRODE_LEVEL_IDX*8 +: 8];

    assign panel_blank = q.panel_blank;
    assign blank_seq_active = q.blank_seq;
    assign core_rst = q.core_rst;
    assign sleep_out = q.sleep_out;
    assign cmd_ready = q.cmd_ok;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    logic [15:0] low_run;
    logic [24:0] rel_run;
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            low_run <= 16'h0000;
            rel_run <= 25'h0;
        end else begin
            low_run <= q.pin_s2 ? 16'h0000 : low_run + 16'h0001;
            rel_run <= (q.state == DHRS_RELEASE) ? rel_run + 25'h1 : 25'h0;
        end
    end

    sequence pin_released_s;
        q.state == DHRS_HOLD ##1 q.state == DHRS_RELEASE;
    endsequence

    glitch_reject_a: assert property (
        $fell(q.pin_f) |-> $past(low_run) >= FILT_CNT)
        else $error("reset accepted from a short pulse");
    spike_hold_a: assert property (
        q.state == DHRS_HOLD && !q.pin_f && q.pin_s2 && q.filt_cnt < FILT_CNT |=>
            q.state == DHRS_HOLD)
        else $error("short spike ended the reset");
    panel_blank_a: assert property (
        q.state != DHRS_RUN |-> q.panel_blank)
        else $error("panel not blank during reset");
    blank_seq_a: assert property (
        $rose(q.blank_seq) |-> q.awake_at_rst && q.tmr == 25'(BLANK_SEQ_CYC - 1))
        else $error("blanking sequence misstarted");
    default_state_a: assert property (
        $past(q.state) == DHRS_RELEASE && q.state == DHRS_RUN |->
            !q.sleep_out && !q.core_rst && q.cmd_ok)
        else $error("defaults not restored");
    load_start_a: assert property (
        pin_released_s |-> q.load_start ##[1:20] nvm_ctl.done)
        else $error("settings reload missing");
    rel_sleep_a: assert property (
        q.state == DHRS_RELEASE && !q.awake_at_rst |-> rel_run < 25'(REL_SLEEP_CYC))
        else $error("release interval too long from sleep");
    rel_awake_a: assert property (
        q.state == DHRS_RELEASE |-> rel_run < 25'(REL_AWAKE_CYC))
        else $error("release interval too long from awake");

endmodule

// *** verif/dhrs_host_model.sv ***
/*
 * Host controller model: drives the reset pin and times its command gates.
 * Assumes the bench calls drive() just after a rising clock edge.
 */
`timescale 1ns/100ps

module dhrs_host_model #(
    parameter int GEN_CYC = 910,
    parameter int WAKE_CYC = 1110
) (
    input wire logic clock,
    output logic hw_reset_pin_n,
    output logic gen_ok,
    output logic wake_ok
);
    int rel_cnt = WAKE_CYC;

    initial hw_reset_pin_n = 1'b1;

    // Gate timer restarts at every pin release
    always @(posedge clock) begin
        if (!hw_reset_pin_n) rel_cnt <= 0;
        else if (rel_cnt < WAKE_CYC) rel_cnt <= rel_cnt + 1;
    end
    assign gen_ok = rel_cnt >= GEN_CYC;
    assign wake_ok = rel_cnt >= WAKE_CYC;

    // Bench picks the width; accepted resets use 10 us or more
    task automatic drive(input logic lvl, input int cyc);
        @(posedge clock);
        hw_reset_pin_n <= lvl;
        repeat (cyc) @(posedge clock);
        #1;
    endtask
endmodule

// *** verif/display_hw_reset_sequencer_tb.sv ***
/*
 * Self-checking bench of the reset sequencer with host model and memory.
 * Assumes shortened release and blanking counts set at the instance.
 */
`timescale 1ns/100ps

module display_hw_reset_sequencer_tb import dhrs_pkg::*;;
    typedef struct {int width; logic awake; logic take;} dhrs_row_t;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic wake_cmd = 1'b0;
    logic sleep_cmd = 1'b0;
    logic pin_n, gen_ok, wake_ok, panel_blank, blank_seq_active, core_rst;
    logic sleep_out, cmd_ready;
    logic [7:0] lvl;
    logic [7:0] nvm_addr, nvm_rdata = 8'h00;
    logic [23:0] id_bytes;
    logic [31:0] settings;
    logic [7:0] mem [4];
    int bad_count = 0;
    int compares = 0;
    dhrs_row_t rows [4] = '{'{1000, 1, 1}, '{400, 1, 0}, '{400, 0, 0}, '{1000, 0, 1}};

    always #5 clock = ~clock;
    always @(posedge clock) nvm_rdata <= mem[nvm_addr[1:0]];

    dhrs_host_model #(.GEN_CYC(910), .WAKE_CYC(1110)) host (.clock(clock),
        .hw_reset_pin_n(pin_n), .gen_ok(gen_ok), .wake_ok(wake_ok));
    dhrs_top #(.REL_SLEEP_CYC(200), .REL_AWAKE_CYC(400),
        .BLANK_SEQ_CYC(600)) dut (.clock(clock), .sys_rst(sys_rst),
        .hw_reset_pin_n(pin_n), .wake_cmd(wake_cmd), .sleep_cmd(sleep_cmd),
        .panel_blank(panel_blank), .blank_seq_active(blank_seq_active),
        .core_rst(core_rst), .sleep_out(sleep_out), .cmd_ready(cmd_ready),
        .nvm_addr(nvm_addr), .nvm_rdata(nvm_rdata), .id_bytes(id_bytes),
        .common_electrode_level(lvl), .settings(settings));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Mode change only once the host gates allow it
    task automatic set_mode(input logic awake);
        wait (wake_ok === 1'b1 && gen_ok === 1'b1 && cmd_ready === 1'b1);
        @(posedge clock);
        wake_cmd <= awake;
        sleep_cmd <= !awake;
        @(posedge clock);
        wake_cmd <= 1'b0;
        sleep_cmd <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
        chk("sleep_out", awake, sleep_out);
        chk("panel_blank", !awake, panel_blank);
    endtask

    task automatic pin_reset(input int width, input logic awake, input logic take, input int spike);
        int rel;
        logic [31:0] exp_set;
        rel = awake ? 400 : 200;
        exp_set = {mem[3], mem[2], mem[1], mem[0]};
        host.drive(1'b0, width);
        chk("core_rst", take, core_rst);
        if (take) begin
            chk("blank", 1'b1, panel_blank);
            chk("blank_seq", awake, blank_seq_active);
            chk("cmd_ready", 1'b0, cmd_ready);
        end
        if (spike > 0) begin
            host.drive(1'b1, spike);
            chk("core_rst spike", 1'b1, core_rst);
            host.drive(1'b0, width);
            chk("blank_seq bound", 1'b0, blank_seq_active);
        end
        host.drive(1'b1, 703 + rel - 30);
        if (take) chk("ready early", 1'b0, cmd_ready);
        host.drive(1'b1, 60);
        chk("ready", 1'b1, cmd_ready);
        chk("core_rst off", 1'b0, core_rst);
        chk("sleep_out rst", take ? 1'b0 : awake, sleep_out);
        chk("blank_seq off", 1'b0, blank_seq_active);
        if (take) begin
            chk("settings", exp_set, settings);
            chk("id", exp_set[23:0], id_bytes);
            chk("level", exp_set[31:24], lvl);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        for (int i = 0; i < 4; i++) mem[i] = 8'ha0 | 8'(i);
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        chk("rst blank", 1'b1, panel_blank);
        chk("rst ready", 1'b1, cmd_ready);
        chk("rst core", 1'b0, core_rst);
        chk("rst sleep", 1'b0, sleep_out);
        chk("rst addr", 8'h00, nvm_addr);
        foreach (rows[i]) begin
            set_mode(rows[i].awake);
            pin_reset(rows[i].width, rows[i].awake, rows[i].take, 0);
        end
        // New stored values must show after the next release
        for (int i = 0; i < 4; i++) mem[i] = 8'h0f ^ 8'(i * 17);
        set_mode(1'b1);
        pin_reset(1000, 1'b1, 1'b1, 300);
        // Mid-run system reset returns outputs to their idle values
        set_mode(1'b1);
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clock);
        #1;
        chk("mid sleep", 1'b0, sleep_out);
        chk("mid blank", 1'b1, panel_blank);
        chk("mid ready", 1'b1, cmd_ready);
        chk("mid settings", 32'h0, settings);
        stop_test();
    end

    initial begin
        repeat (40000) @(posedge clock);
        bad_count++;
        stop_test();
    end
endmodule
